/* File: include/led_head_pkg.sv */
package led_head_pkg;

    // geometry
    localparam int DOT_COUNT = 4992;
    localparam int GROUPS = 4;
    localparam int NIB_W = 4;
    localparam int FIFO_WORDS = 32;
    localparam int DRV_W = 7;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_NVM_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] REG_NVM_DATA = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_LINE_CNT = 8'h10;

    // control mode field, codes as written by software
    localparam int CTRL_MODE_LSB = 0;
    localparam logic [1:0] CODE_NORMAL = 2'h0;
    localparam logic [1:0] CODE_READ = 2'h1;
    localparam logic [1:0] CODE_DIRECT = 2'h2;

    // status field positions
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_LD_LSB = 4;
    localparam int STAT_FILL_LSB = 8;
    localparam int STAT_RIDX_LSB = 16;

    // drive level in percent of nominal current
    localparam logic [DRV_W-1:0] NOMINAL_PCT = 7'h64;
    localparam logic [DRV_W-1:0] STEP_PCT = 7'h02;
    localparam logic [DRV_W-1:0] DRV_MIN_PCT = 7'h56;
    localparam logic [DRV_W-1:0] DRV_MAX_PCT = 7'h74;
    localparam logic [NIB_W-1:0] CORR_MAX_UP = 4'h8;
    localparam logic [NIB_W:0] CORR_SPAN = 5'h10;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_READ = 3'b010,
        MODE_DIRECT = 3'b100
    } mode_t;

    typedef enum logic [2:0] {
        LD_IDLE = 3'b001,
        LD_DRAIN = 3'b010,
        LD_COPY = 3'b100
    } load_t;

    // 0 nominal, 1..7 and 8 step up, 15 down to 9 step down
    function automatic logic [DRV_W-1:0] corrPct(input logic [NIB_W-1:0] c);
        if (!c[NIB_W-1] || c == CORR_MAX_UP) begin
            return NOMINAL_PCT + STEP_PCT * DRV_W'(c);
        end
        return NOMINAL_PCT - STEP_PCT * DRV_W'(CORR_SPAN - {1'b0, c});
    endfunction

endpackage

/* File: src/nibble_fifo.sv */
module nibble_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // level
    output logic [$clog2(DEPTH):0] fill
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } fifo_t;

    fifo_t st;
    fifo_t nxt_st;
    logic doPush;
    logic doPop;

    // count is one bit wider than the pointers so that a full queue is not read as empty
    assign inReady = (st.cnt != (PW+1)'(DEPTH));
    assign outValid = (st.cnt != '0);
    assign outData = st.mem[st.rp];
    assign fill = st.cnt;
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    function automatic logic [PW-1:0] wrapInc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        nxt_st = st;
        if (doPush) begin
            nxt_st.mem[st.wp] = inData;
            nxt_st.wp = wrapInc(st.wp);
        end
        if (doPop) begin
            nxt_st.rp = wrapInc(st.rp);
        end
        nxt_st.cnt = st.cnt + (PW+1)'(doPush) - (PW+1)'(doPop);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= nxt_st;
        end
    end
endmodule

/* File: src/led_head_line_loader.sv */
// Operation
// (RULE1) each dot's light is adjustable in sixteen steps around nominal
// (RULE2) every dot holds a four-bit correction value loaded by the controller
// (RULE3) nibble decode: 0 none, 1-7 up 2-14%, 8 up 16%, 15-9 down 2-14%
// (RULE4) correction changes the dot's drive current, never its on/off pattern
// (RULE5) correction values live in nonvolatile storage inside the head
// (RULE6) controller first reads every stored value in read mode and keeps it
// (RULE7) controller then writes the kept values into the drivers in direct mode
// (RULE8) controller processor sequences read-out and write-back, not head logic
// (RULE9) head starts in normal mode and is normal whenever load line is low
// (RULE10) normal mode shifts one print nibble per rising data clock
// (RULE11) one high load pulse copies the shift register into the latches
// (RULE12) latched data lights LEDs only while the four group strobes are asserted
// (RULE13) the head holds one dot line of 4992 LEDs
// (RULE14) each group strobe is active low
// (RULE15) controller loads the next line only after strobes are released
//
// The address map and strobed register access were chosen for this implementation.
module led_head_line_loader
    import led_head_pkg::*;
#(
    parameter int DOTS = DOT_COUNT,
    parameter int FIFO_DEPTH = FIFO_WORDS
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    // head link pins
    input wire logic dataClk,
    input wire logic printNibbleBit0,
    input wire logic printNibbleBit1,
    input wire logic printNibbleBit2,
    input wire logic printNibbleBit3,
    input wire logic latchLoad,
    input wire logic emitGateGroup1_n,
    input wire logic emitGateGroup2_n,
    input wire logic emitGateGroup3_n,
    input wire logic emitGateGroup4_n,
    output logic [NIB_W-1:0] corrReadNibble,
    output logic dataReady,
    // LED drive, percent of nominal current, zero when dark
    output logic [DOTS-1:0][DRV_W-1:0] ledDrive
);
    localparam int IW = $clog2(DOTS + 1);
    localparam int GSIZE = DOTS / GROUPS;
    localparam int FW = $clog2(FIFO_DEPTH) + 1;

    typedef struct packed {
        logic [2:0] clkS;
        logic [2:0] loadS;
        logic [1:0][GROUPS-1:0] stbS;
        logic [1:0][NIB_W-1:0] nibS;
        mode_t mode;
        load_t ld;
        logic [IW-1:0] nvmAddr;
        logic [IW-1:0] readIdx;
        logic [NIB_W-1:0] readNib;
        logic [CNT_W-1:0] lineCnt;
        logic [DATA_W-1:0] rdData;
        logic [DOTS-1:0] shiftReg;
        logic [DOTS-1:0] latched;
        logic [DOTS-1:0][NIB_W-1:0] corr;
        logic [DOTS-1:0][NIB_W-1:0] nvm;
        logic [DOTS-1:0][DRV_W-1:0] drive;
    } state_t;

    state_t st;
    state_t nxt_st;
    mode_t effMode;
    logic clkRise;
    logic loadRise;
    logic pushValid;
    logic pushReady;
    logic [NIB_W:0] pushData;
    logic popValid;
    logic popReady;
    logic [NIB_W:0] popData;
    logic [FW-1:0] fifoFill;
    logic popTake;

    function automatic mode_t modeDecode(input logic [1:0] code);
        case (code)
            CODE_READ: return MODE_READ;
            CODE_DIRECT: return MODE_DIRECT;
            default: return MODE_NORMAL;
        endcase
    endfunction

    // correction modes only exist while the load line is held high
    assign effMode = st.loadS[1] ? st.mode : MODE_NORMAL; // RULE9
    assign clkRise = st.clkS[1] && !st.clkS[2];
    assign loadRise = st.loadS[1] && !st.loadS[2] && st.mode == MODE_NORMAL;
    assign pushValid = clkRise && effMode != MODE_READ;
    assign pushData = {effMode == MODE_DIRECT, st.nibS[1]};
    // drain stalls for the copy cycle so a line never tears
    assign popReady = (st.ld != LD_COPY);
    assign popTake = popValid && popReady;
    assign dataReady = pushReady;
    assign corrReadNibble = st.readNib;
    assign regRdData = st.rdData;
    assign ledDrive = st.drive;

    nibble_fifo #(
        .WIDTH(NIB_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushData),
        .outValid(popValid),
        .outReady(popReady),
        .outData(popData),
        .fill(fifoFill)
    );

    always_comb begin
        nxt_st = st;
        nxt_st.clkS = {st.clkS[1:0], dataClk};
        nxt_st.loadS = {st.loadS[1:0], latchLoad};
        nxt_st.stbS = {st.stbS[0],
            {emitGateGroup4_n, emitGateGroup3_n, emitGateGroup2_n, emitGateGroup1_n}};
        nxt_st.nibS = {st.nibS[0],
            {printNibbleBit3, printNibbleBit2, printNibbleBit1, printNibbleBit0}};

        // read-out of stored corrections, one nibble per data clock
        if (clkRise && effMode == MODE_READ) begin
            nxt_st.readNib = st.nvm[st.readIdx]; // RULE5
            nxt_st.readIdx = (st.readIdx == IW'(DOTS - 1)) ? '0 : st.readIdx + 1'b1;
        end

        if (popTake) begin
            if (popData[NIB_W]) begin
                nxt_st.corr = {st.corr[DOTS-2:0], popData[NIB_W-1:0]}; // RULE2
            end else begin
                nxt_st.shiftReg = {st.shiftReg[DOTS-NIB_W-1:0], popData[NIB_W-1:0]}; // RULE10 RULE13
            end
        end

        case (st.ld)
            LD_IDLE: begin
                if (loadRise) begin
                    nxt_st.ld = LD_DRAIN;
                end
            end
            LD_DRAIN: begin
                // nibbles still queued belong to the line being latched
                if (!popValid) begin
                    nxt_st.ld = LD_COPY;
                end
            end
            LD_COPY: begin
                nxt_st.latched = st.shiftReg; // RULE11
                nxt_st.lineCnt = st.lineCnt + 1'b1;
                nxt_st.ld = LD_IDLE;
            end
            default: nxt_st.ld = LD_IDLE;
        endcase

        for (int d = 0; d < DOTS; d++) begin
            // pattern picks on/off, correction only scales current
            nxt_st.drive[d] = (st.latched[d] && !st.stbS[1][d / GSIZE]) ? // RULE12 RULE14
                corrPct(st.corr[d]) : '0; // RULE1 RULE3 RULE4
        end

        if (regWr) begin
            case (regAddr)
                REG_CTRL: begin
                    nxt_st.mode = modeDecode(regWrData[CTRL_MODE_LSB +: 2]);
                    nxt_st.readIdx = '0;
                end
                REG_NVM_ADDR: nxt_st.nvmAddr = regWrData[IW-1:0];
                REG_NVM_DATA: begin
                    if (st.nvmAddr < IW'(DOTS)) begin
                        nxt_st.nvm[st.nvmAddr] = regWrData[NIB_W-1:0]; // RULE5
                    end
                end
                default: ;
            endcase
        end

        nxt_st.rdData = '0;
        if (regRd) begin
            case (regAddr)
                REG_CTRL: begin
                    nxt_st.rdData[CTRL_MODE_LSB +: 2] = (st.mode == MODE_READ) ? CODE_READ :
                        (st.mode == MODE_DIRECT) ? CODE_DIRECT : CODE_NORMAL;
                end
                REG_STATUS: begin
                    nxt_st.rdData[STAT_MODE_LSB +: 3] = effMode;
                    nxt_st.rdData[STAT_LD_LSB +: 3] = st.ld;
                    nxt_st.rdData[STAT_FILL_LSB +: FW] = fifoFill;
                    nxt_st.rdData[STAT_RIDX_LSB +: IW] = st.readIdx;
                end
                REG_NVM_ADDR: nxt_st.rdData[IW-1:0] = st.nvmAddr;
                REG_NVM_DATA: begin
                    if (st.nvmAddr < IW'(DOTS)) begin
                        nxt_st.rdData[NIB_W-1:0] = st.nvm[st.nvmAddr];
                    end
                end
                REG_LINE_CNT: nxt_st.rdData[CNT_W-1:0] = st.lineCnt;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.mode <= MODE_NORMAL; // RULE9
            st.ld <= LD_IDLE;
            st.stbS <= '1;
            // stored corrections must outlive reset
            st.nvm <= st.nvm;
        end else if (ce) begin
            st <= nxt_st;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_drive_range: assert property ( // RULE1
        st.drive[0] == '0 || (st.drive[0] >= DRV_MIN_PCT && st.drive[0] <= DRV_MAX_PCT))
        else $error("drive level outside the sixteen-step range");

    chk_drive_decode: assert property ( // RULE3
        ce && st.latched[0] && !st.stbS[1][0] |=> st.drive[0] == corrPct($past(st.corr[0])))
        else $error("lit dot drive does not match its correction value");

    chk_dark_gate: assert property ( // RULE12
        ce && (st.stbS[1][0] || !st.latched[0]) |=> st.drive[0] == '0)
        else $error("dot lit without strobe or latched data");

    chk_normal_low: assert property ( // RULE9
        !st.loadS[1] |-> effMode == MODE_NORMAL && !(pushValid && pushData[NIB_W]))
        else $error("correction mode active while load line low");

    chk_shift_nibble: assert property ( // RULE10
        ce && popTake && !popData[NIB_W] |=> st.shiftReg[NIB_W-1:0] == $past(popData[NIB_W-1:0]))
        else $error("print nibble not shifted in");

    chk_corr_load: assert property ( // RULE2
        ce && popTake && popData[NIB_W] |=> st.corr[0] == $past(popData[NIB_W-1:0]))
        else $error("direct-mode nibble not loaded into driver correction");

    chk_latch_copy: assert property ( // RULE11
        ce && st.ld == LD_COPY |=> st.latched == $past(st.shiftReg)
            && st.lineCnt == $past(st.lineCnt) + 1'b1)
        else $error("latch copy or line count wrong");

    chk_latch_order: assert property ( // RULE11
        ce && st.ld == LD_IDLE && loadRise |=> st.ld == LD_DRAIN ##1 st.latched == $past(st.latched))
        else $error("latch taken before queued nibbles drained");

    chk_read_nibble: assert property ( // RULE5
        ce && clkRise && effMode == MODE_READ |=> st.readNib == $past(st.nvm[st.readIdx]))
        else $error("read-out nibble not taken from stored corrections");
endmodule

/* File: test/led_board_model.sv */
module led_board_model (
    // system
    input wire logic clk,
    // print data pins
    output logic dataClk,
    output logic [3:0] nibble,
    // line control pins
    output logic latchLoad,
    output logic [3:0] strobe_n
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        dataClk = 1'b0;
        nibble = 4'h0;
        latchLoad = 1'b0;
        strobe_n = 4'hf;
    end

    // data clock low 4 clk and high 4 clk; nibble settles 3 clk before the rise
    task automatic sendNibble(input logic [3:0] n);
        @(posedge clk);
        nibble <= n;
        repeat (3) @(posedge clk);
        dataClk <= 1'b1;
        repeat (4) @(posedge clk);
        dataClk <= 1'b0;
        // hold time is over, so the lines no longer show the value
        nibble <= ~n;
    endtask

    // level held 6 clk so the head's synchronisers see it
    task automatic setLoad(input logic v);
        @(posedge clk);
        latchLoad <= v;
        repeat (6) @(posedge clk);
    endtask

    // low lights the group; next line only after all are released
    task automatic setStrobes(input logic [3:0] s);
        @(posedge clk);
        strobe_n <= s;
        repeat (6) @(posedge clk);
    endtask
endmodule

/* File: test/led_head_line_loader_bench.sv */
module led_head_line_loader_bench
    import led_head_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int NDOTS = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic dataClk;
    logic latchLoad;
    logic [3:0] nibble;
    logic [3:0] strobe_n;
    logic [NIB_W-1:0] corrReadNibble;
    logic dataReady;
    logic [NDOTS-1:0][DRV_W-1:0] ledDrive;
    logic [NDOTS-1:0][3:0] corr = '0;
    logic [NDOTS-1:0][3:0] kept = '0;
    int num_errors = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    led_board_model i_led_board_model (
        .clk(clk), .dataClk(dataClk), .nibble(nibble),
        .latchLoad(latchLoad), .strobe_n(strobe_n)
    );

    led_head_line_loader #(.DOTS(NDOTS), .FIFO_DEPTH(FIFO_WORDS)) i_led_head_line_loader (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .dataClk(dataClk),
        .printNibbleBit0(nibble[0]), .printNibbleBit1(nibble[1]),
        .printNibbleBit2(nibble[2]), .printNibbleBit3(nibble[3]),
        .latchLoad(latchLoad),
        .emitGateGroup1_n(strobe_n[0]), .emitGateGroup2_n(strobe_n[1]),
        .emitGateGroup3_n(strobe_n[2]), .emitGateGroup4_n(strobe_n[3]),
        .corrReadNibble(corrReadNibble), .dataReady(dataReady), .ledDrive(ledDrive)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask

    function automatic logic [31:0] pctOf(input logic [3:0] c);
        if (c <= 4'h8) begin
            return 32'h0000_0064 + 32'(c) * 2;
        end
        return 32'h0000_0064 - (32'h0000_0010 - 32'(c)) * 2;
    endfunction

    task automatic checkLeds(input logic [15:0] lit);
        for (int d = 0; d < NDOTS; d++) begin
            check("ledDrive", 32'(ledDrive[d]), lit[d] ? pctOf(corr[d]) : '0);
        end
    endtask

    // first nibble ends at the top dots
    task automatic sendLine(input logic [15:0] bits);
        for (int i = 0; i < 4; i++) begin
            i_led_board_model.sendNibble(bits[15 - 4 * i -: 4]);
        end
        i_led_board_model.setLoad(1'b1);
        i_led_board_model.setLoad(1'b0);
    endtask

    task automatic testReset();
        logic [31:0] d;
        check("regRdData", regRdData, '0);
        check("corrReadNibble", 32'(corrReadNibble), '0);
        check("dataReady", 32'(dataReady), 32'h0000_0001);
        checkLeds(16'h0000);
        regRead(REG_STATUS, d);
        check("status", d, 32'h0000_0011);
        regRead(8'h14, d);
        check("unmapped", d, '0);
        $display("test reset done");
    endtask

    task automatic testPrint(input logic [15:0] bits, input logic [31:0] lines);
        logic [31:0] d;
        sendLine(bits);
        checkLeds(16'h0000);
        i_led_board_model.setStrobes(4'hb);
        checkLeds(bits & 16'h0f00);
        i_led_board_model.setStrobes(4'h0);
        checkLeds(bits);
        i_led_board_model.setStrobes(4'hf);
        checkLeds(16'h0000);
        regRead(REG_LINE_CNT, d);
        check("lineCnt", d, lines);
        $display("test print done");
    endtask

    task automatic testDirect();
        regWrite(REG_CTRL, 32'(CODE_DIRECT));
        i_led_board_model.setLoad(1'b1);
        // kept values go out top dot first so the last one lands on dot 0
        for (int k = 0; k < NDOTS; k++) begin
            i_led_board_model.sendNibble(kept[NDOTS - 1 - k]);
            corr[k] = 4'((k * 7 + 3) % 16);
        end
        i_led_board_model.setLoad(1'b0);
        regWrite(REG_CTRL, 32'(CODE_NORMAL));
        $display("test direct done");
        testPrint(16'hffff, 32'h0000_0002);
    endtask

    task automatic testRead();
        logic [31:0] d;
        for (int k = 0; k < NDOTS; k++) begin
            regWrite(REG_NVM_ADDR, 32'(k));
            regWrite(REG_NVM_DATA, 32'((k * 7 + 3) % 16));
        end
        regRead(REG_NVM_DATA, d);
        check("nvmData", d, 32'(15 * 7 % 16 + 3 - 16 * ((15 * 7 % 16 + 3) / 16)));
        regWrite(REG_NVM_ADDR, 32'(NDOTS));
        regRead(REG_NVM_DATA, d);
        check("nvmOutside", d, '0);
        regWrite(REG_CTRL, 32'(CODE_READ));
        i_led_board_model.setLoad(1'b1);
        for (int k = 0; k < NDOTS; k++) begin
            i_led_board_model.sendNibble(4'h5);
            #1 check("corrRead", 32'(corrReadNibble), 32'((k * 7 + 3) % 16));
            kept[k] = corrReadNibble;
        end
        i_led_board_model.setLoad(1'b0);
        regWrite(REG_CTRL, 32'(CODE_NORMAL));
        $display("test read done");
    endtask

    // strobes and a control write while frozen must leave no trace
    task automatic testFreeze();
        logic [31:0] d;
        @(posedge clk);
        ce <= 1'b0;
        i_led_board_model.setStrobes(4'h0);
        checkLeds(16'h0000);
        regWrite(REG_CTRL, 32'(CODE_READ));
        @(posedge clk);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        #1 checkLeds(16'hffff);
        i_led_board_model.setStrobes(4'hf);
        regRead(REG_CTRL, d);
        check("ctrlFrozen", d, 32'(CODE_NORMAL));
        $display("test freeze done");
    endtask

    // a reset in mid-run clears the line but not the stored corrections
    task automatic testRetain();
        logic [31:0] d;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 checkLeds(16'h0000);
        i_led_board_model.setStrobes(4'h0);
        checkLeds(16'h0000);
        i_led_board_model.setStrobes(4'hf);
        regRead(REG_LINE_CNT, d);
        check("lineCnt", d, '0);
        regRead(REG_STATUS, d);
        check("status", d, 32'h0000_0011);
        regWrite(REG_NVM_ADDR, 32'h0000_0003);
        regRead(REG_NVM_DATA, d);
        check("nvmKept", d, 32'((3 * 7 + 3) % 16));
        $display("test retain done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 testReset();
        testPrint(16'h81a3, 32'h0000_0001);
        testRead();
        testDirect();
        testFreeze();
        testRetain();
        summarize();
    end
endmodule
